// file: core/usb_parallel_fifo_port.sv
// Parallel FIFO port: receive and transmit byte queues behind strobes.
// Assumes the USB engine feeds rx_in and drains tx_out on core_clk;
// pins from external logic are asynchronous and synchronised here.
// Functional notes
// RULE1 - Power indicator low once configured, high while suspended.
// RULE2 - Drive current receive byte on data lines while read strobe low.
// RULE3 - Read strobe falling edge fetches next receive byte if available.
// RULE4 - Write strobe falling edge captures data lines into transmit queue.
// RULE5 - External logic never writes while transmit-ready output is high.
// RULE6 - External logic writes one byte by strobing write high then low.
// RULE7 - External logic never reads while receive-available is high.
// RULE8 - Receive-available low whenever a byte is buffered; read by strobe. Code holds it high while the read strobe is low.
// RULE9 - Both status outputs float while the device is in reset.
// RULE10 - Wakeup enabled and suspended: receive-available pin becomes input.
// RULE11 - Receive-available pin low 20 ms in suspend requests USB resume.
// RULE12 - Input pins pull up; option makes them pull low in suspend.
// RULE13 - Active-low reset input returns the port to its reset state. Code floats data and status pins; queues keep their bytes.
// RULE14 - Controller runs from the single reference clock.
// RULE15 - Flush partial data after timeout, 16 ms default, 2 to 255 ms.
// RULE16 - External logic never overlaps strobes; releases data when idle.
`timescale 1ns/100ps
`default_nettype none
module usb_parallel_fifo_port #(
    parameter int WAKE_CYCLES = fifo_port_pkg::WAKE_CYC,
    parameter int MS_CYCLES = fifo_port_pkg::MS_CYC,
    parameter int RX_DEPTH = fifo_port_pkg::RX_DEPTH,
    parameter int TX_DEPTH = fifo_port_pkg::TX_DEPTH
) (
    input wire logic core_clk, // Reference clock
    input wire logic rst, // Core reset, active high
    input wire logic ext_reset_n, // Reset pin from external logic
    input wire logic rd_strobe_n, // Read strobe pin
    input wire logic wr_strobe, // Write strobe pin
    input wire logic [7:0] fifo_data_in, // Data pins, input side
    output logic [7:0] fifo_data_out, // Data pins, output side
    output logic fifo_data_oe, // Data pins driven
    output logic rx_byte_avail_n, // Receive-available level
    output logic rx_byte_avail_oe, // Receive-available driven
    input wire logic rx_byte_avail_in, // Receive-available pin sensed
    output logic tx_space_avail_n, // Transmit-ready level
    output logic tx_space_avail_oe, // Transmit-ready driven
    output logic usb_power_ok_n, // Power indicator
    output logic pins_pull_low, // Input pull toward ground
    input wire logic usb_configured, // From USB engine
    input wire logic usb_suspended, // From USB engine
    input wire logic wakeup_enable, // Stored wakeup option
    input wire logic suspend_pulldown_en, // Stored pull-down option
    input wire logic [7:0] flush_ms, // Flush timeout setting, ms
    output logic resume_request, // One-cycle resume request
    input wire logic [7:0] rx_in_data, // Byte from USB
    input wire logic rx_in_valid, // Byte from USB valid
    output logic rx_in_ready, // Receive queue has room
    output logic [7:0] tx_out_data, // Byte to USB
    output logic tx_out_valid, // Byte to USB valid
    input wire logic tx_out_ready, // USB takes byte
    output logic tx_flush // One-cycle flush of partial data
);
    // -------------------------------------------------------------------
    // Reset and pin synchronisers
    // -------------------------------------------------------------------
    logic [1:0] xrst_sync;
    logic [1:0] rd_sync;
    logic [1:0] wr_sync;
    logic [1:0] wk_sync;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic rd_prev;
    logic wr_prev;
    logic port_rst;

    // Pin reset held as a synchronised level
    always_ff @(posedge core_clk or posedge rst) begin // RULE14
        if (rst) begin
            xrst_sync <= 2'h0;
        end else begin
            xrst_sync <= {xrst_sync[0], ext_reset_n};
        end
    end
    assign port_rst = ~xrst_sync[1]; // RULE13

    // Two flops on every asynchronous pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_sync <= 2'h3;
            wr_sync <= 2'h0;
            wk_sync <= 2'h3;
            din_s1 <= fifo_port_pkg::BYTE_RESET;
            din_s2 <= fifo_port_pkg::BYTE_RESET;
            rd_prev <= 1'b1;
            wr_prev <= 1'b0;
        end else begin
            rd_sync <= {rd_sync[0], rd_strobe_n};
            wr_sync <= {wr_sync[0], wr_strobe};
            wk_sync <= {wk_sync[0], rx_byte_avail_in};
            din_s1 <= fifo_data_in;
            din_s2 <= din_s1;
            rd_prev <= rd_sync[1];
            wr_prev <= wr_sync[1];
        end
    end

    wire rd_fall = rd_prev & ~rd_sync[1];
    wire wr_fall = wr_prev & ~wr_sync[1];

    // -------------------------------------------------------------------
    // Link state and power indicator
    // -------------------------------------------------------------------
    fifo_port_pkg::link_state_t link;
    fifo_port_pkg::link_state_t next_link;
    always_comb begin
        next_link = link;
        unique case (link)
            fifo_port_pkg::LINK_IDLE:
                if (usb_configured) next_link = fifo_port_pkg::LINK_CONFIGURED;
            fifo_port_pkg::LINK_CONFIGURED:
                if (usb_suspended) next_link = fifo_port_pkg::LINK_SUSPENDED;
                else if (!usb_configured) next_link = fifo_port_pkg::LINK_IDLE;
            fifo_port_pkg::LINK_SUSPENDED:
                if (!usb_suspended) next_link = fifo_port_pkg::LINK_CONFIGURED;
            default: next_link = fifo_port_pkg::LINK_IDLE;
        endcase
    end
    wire suspended = (next_link == fifo_port_pkg::LINK_SUSPENDED);
    wire wake_mode = wakeup_enable && suspended;
    wire powered_n = (next_link != fifo_port_pkg::LINK_CONFIGURED);

    // -------------------------------------------------------------------
    // Byte queues
    // -------------------------------------------------------------------
    logic [7:0] rx_head;
    logic rx_has;
    logic [$clog2(RX_DEPTH):0] rx_level;
    logic tx_room;
    logic [$clog2(TX_DEPTH):0] tx_level;
    logic rx_loaded;
    logic [7:0] rx_hold;
    wire rx_fetch = rd_fall && rx_has && !port_rst; // RULE3
    wire tx_push = wr_fall && tx_room && !port_rst; // RULE4
    // Data lines driven from the fetch until the strobe rises
    wire rx_drive = !port_rst && !rd_sync[1] && // RULE2
        (rx_fetch || rx_loaded);

    byte_queue #(.WIDTH(8), .DEPTH(RX_DEPTH)) rx_queue (
        .core_clk(core_clk), .rst(rst),
        .in_data(rx_in_data), .in_valid(rx_in_valid),
        .in_ready(rx_in_ready), .out_data(rx_head),
        .out_valid(rx_has), .out_ready(rx_fetch), .level(rx_level)
    );
    byte_queue #(.WIDTH(8), .DEPTH(TX_DEPTH)) tx_queue (
        .core_clk(core_clk), .rst(rst),
        .in_data(din_s2), .in_valid(tx_push),
        .in_ready(tx_room), .out_data(tx_out_data),
        .out_valid(tx_out_valid), .out_ready(tx_out_ready),
        .level(tx_level)
    );

    // -------------------------------------------------------------------
    // Flush timer and wakeup timer
    // -------------------------------------------------------------------
    logic [31:0] ms_cnt;
    logic [7:0] ms_elapsed;
    logic [31:0] wake_cnt;
    wire [7:0] flush_lim = (flush_ms < fifo_port_pkg::FLUSH_MS_MIN) ?
        fifo_port_pkg::FLUSH_MS_MIN : flush_ms;
    wire ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
    wire flush_due = tx_out_valid && !tx_push &&
        ms_tick && (ms_elapsed + 8'h01 >= flush_lim); // RULE15
    wire elapsed_max = (ms_elapsed == fifo_port_pkg::FLUSH_MS_MAX);
    wire wake_low = wake_mode && !wk_sync[1];
    wire wake_due = wake_low && (wake_cnt == 32'(WAKE_CYCLES - 1)); // RULE11

    // Timers restart on new transmit data or when the pin rises
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ms_cnt <= '0;
            ms_elapsed <= 8'h00;
            wake_cnt <= '0;
        end else begin
            ms_cnt <= (tx_push || !tx_out_valid || ms_tick) ? '0 : ms_cnt + 1;
            if (tx_push || !tx_out_valid || flush_due) begin
                ms_elapsed <= 8'h00;
            end else if (ms_tick && !elapsed_max) begin
                ms_elapsed <= ms_elapsed + 8'h01;
            end
            wake_cnt <= (!wake_low || wake_due) ? '0 : wake_cnt + 1;
        end
    end

    // -------------------------------------------------------------------
    // Pin outputs, all registered
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link <= fifo_port_pkg::LINK_IDLE;
            rx_loaded <= 1'b0;
            rx_hold <= fifo_port_pkg::BYTE_RESET;
            fifo_data_out <= fifo_port_pkg::BYTE_RESET;
            fifo_data_oe <= 1'b0;
            rx_byte_avail_n <= 1'b1;
            rx_byte_avail_oe <= 1'b0;
            tx_space_avail_n <= 1'b1;
            tx_space_avail_oe <= 1'b0;
            usb_power_ok_n <= 1'b1;
            pins_pull_low <= 1'b0;
            resume_request <= 1'b0;
            tx_flush <= 1'b0;
        end else begin
            link <= next_link;
            if (rx_fetch) begin
                rx_hold <= rx_head;
            end
            rx_loaded <= !port_rst && (rx_fetch || (rx_loaded && !rd_sync[1]));
            fifo_data_out <= rx_fetch ? rx_head : rx_hold; // RULE2
            fifo_data_oe <= rx_drive; // RULE2
            rx_byte_avail_n <= !(rx_has && rd_sync[1]); // RULE8
            rx_byte_avail_oe <= !port_rst && !wake_mode; // RULE9 RULE10
            tx_space_avail_n <= !(tx_room && !wr_sync[1]); // RULE5
            tx_space_avail_oe <= !port_rst; // RULE9
            usb_power_ok_n <= powered_n; // RULE1
            pins_pull_low <= suspend_pulldown_en && suspended; // RULE12
            resume_request <= wake_due; // RULE11
            tx_flush <= flush_due; // RULE15
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    // Quiet time since the last write, counted apart from the flush timer
    logic [31:0] quiet_cyc;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            quiet_cyc <= '0;
        end else if (tx_push || !tx_out_valid || flush_due) begin
            quiet_cyc <= '0;
        end else begin
            quiet_cyc <= quiet_cyc + 32'h1;
        end
    end

    a_power_when_config: assert property ( // RULE1
        @(posedge core_clk) disable iff (rst)
        next_link == fifo_port_pkg::LINK_CONFIGURED |=> !usb_power_ok_n)
        else $error("power indicator not low when configured");
    a_power_in_suspend: assert property ( // RULE1
        @(posedge core_clk) disable iff (rst)
        suspended |=> usb_power_ok_n)
        else $error("power indicator not high in suspend");
    a_rx_data_drive: assert property ( // RULE2
        @(posedge core_clk) disable iff (rst)
        rx_fetch |=> fifo_data_oe && fifo_data_out == $past(rx_head))
        else $error("fetched byte not driven");
    a_rx_fetch_edge: assert property ( // RULE3
        @(posedge core_clk) disable iff (rst)
        rx_fetch |-> $past(rd_sync[1]) && !rd_sync[1])
        else $error("fetch without strobe fall");
    a_tx_capture: assert property ( // RULE4
        @(posedge core_clk) disable iff (rst)
        tx_push |=> tx_level == $past(tx_level) + 1'b1 || $past(tx_out_ready))
        else $error("write not captured");
    a_rx_avail_level: assert property ( // RULE8
        @(posedge core_clk) disable iff (rst)
        !rx_has |=> rx_byte_avail_n)
        else $error("avail low with empty queue");
    a_status_float_rst: assert property ( // RULE9
        @(posedge core_clk) disable iff (rst)
        port_rst |=> !rx_byte_avail_oe && !tx_space_avail_oe)
        else $error("status driven in reset");
    a_wake_input: assert property ( // RULE10
        @(posedge core_clk) disable iff (rst)
        wake_mode |=> !rx_byte_avail_oe)
        else $error("avail pin driven in wakeup mode");
    a_resume_time: assert property ( // RULE11
        @(posedge core_clk) disable iff (rst)
        resume_request |-> $past(wake_cnt) == 32'(WAKE_CYCLES - 1))
        else $error("resume before wakeup time");
    a_flush_time: assert property ( // RULE15
        @(posedge core_clk) disable iff (rst)
        flush_due |-> quiet_cyc >= 32'(flush_lim) * 32'(MS_CYCLES) - 32'h1)
        else $error("flush before timeout");
    c_read: cover property (@(posedge core_clk) disable iff (rst) rx_fetch);
    c_write: cover property (@(posedge core_clk) disable iff (rst) tx_push);
    c_resume: cover property (@(posedge core_clk) disable iff (rst)
        resume_request);
    c_flush: cover property (@(posedge core_clk) disable iff (rst) tx_flush);
endmodule
`default_nettype wire

// file: core/fifo_port_pkg.sv
// Constants shared by the parallel FIFO port of the USB bridge.
// Assumes a single 50 MHz core clock.
package fifo_port_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int DATA_W = 8;
    localparam int RX_DEPTH = 128;
    localparam int TX_DEPTH = 256;
    // Wakeup low time, in ms, and its least cycle count
    localparam int WAKE_MS = 20;
    localparam int WAKE_CYC = (CLK_HZ / 1000) * WAKE_MS;
    // Flush timeout in ms: default, least and most, and cycles per ms
    localparam logic [7:0] FLUSH_MS_DEF = 8'h10;
    localparam logic [7:0] FLUSH_MS_MIN = 8'h02;
    localparam logic [7:0] FLUSH_MS_MAX = 8'hFF;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_CONFIGURED = 2'b01,
        LINK_SUSPENDED = 2'b11
    } link_state_t;
endpackage

// file: core/byte_queue.sv
// Byte queue with valid/ready on both sides; full and empty are honest.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module byte_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128
) (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Asynchronous reset
    input wire logic [WIDTH-1:0] in_data, // Write data
    input wire logic in_valid, // Write request
    output logic in_ready, // Not full
    output logic [WIDTH-1:0] out_data, // Head byte
    output logic out_valid, // Not empty
    input wire logic out_ready, // Pop request
    output logic [$clog2(DEPTH):0] level // Bytes held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Status from the fill count
    assign in_ready = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];

    // Storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// file: tb/fifo_host_model.sv
// External host logic model: strobes, data pins and wakeup pin.
// Assumes core_clk at 50 MHz; each strobe phase lasts six cycles, except the read low phase of seven.
`timescale 1ns/100ps
`default_nettype none
module fifo_host_model (
    input wire logic core_clk, // Reference clock
    input wire logic fifo_data_oe, // Port drives data pins
    input wire logic [7:0] fifo_data_out, // Port data
    input wire logic rx_byte_avail_oe, // Port drives status pin
    input wire logic rx_byte_avail_n, // Port status level
    output logic rd_strobe_n, // Read strobe
    output logic wr_strobe, // Write strobe
    output logic [7:0] fifo_data_in, // Resolved data pins
    output logic rx_pin // Resolved receive-available pin
);
    logic host_oe = 1'b0;
    logic [7:0] host_data = 8'h00;
    logic wake_low = 1'b0;
    initial begin
        rd_strobe_n = 1'b1;
        wr_strobe = 1'b0;
    end
    // Pin resolution; released data lines float to the pull-up level
    assign fifo_data_in = fifo_data_oe ? fifo_data_out :
        (host_oe ? host_data : 8'hFF);
    assign rx_pin = rx_byte_avail_oe ? rx_byte_avail_n : !wake_low;
    // One write: strobe high, then low, data held across the fall
    task automatic write_byte(input logic [7:0] b);
        @(posedge core_clk) #2;
        host_oe = 1'b1;
        host_data = b;
        wr_strobe = 1'b1;
        repeat (6) @(posedge core_clk);
        #2 wr_strobe = 1'b0;
        repeat (6) @(posedge core_clk);
        #2 host_oe = 1'b0;
    endtask
    // One read: strobe low, then high; never overlaps a write
    task automatic read_byte();
        @(posedge core_clk) #2;
        rd_strobe_n = 1'b0;
        repeat (7) @(posedge core_clk);
        #2 rd_strobe_n = 1'b1;
        repeat (6) @(posedge core_clk);
    endtask
    // Hold the receive-available pin low for n cycles in suspend
    task automatic wake_strobe(input int n);
        @(posedge core_clk) #2;
        wake_low = 1'b1;
        repeat (n) @(posedge core_clk);
        #2 wake_low = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/usb_parallel_fifo_port_tb_top.sv
// Self-checking bench for the parallel FIFO port.
// Assumes shortened counts: wake 50, ms 20 cycles, queues of four.
`timescale 1ns/100ps
`default_nettype none
module usb_parallel_fifo_port_tb_top;
    localparam int WK = 50;
    localparam int MS = 20;
    localparam int DP = 4;
    logic core_clk, rst, ext_reset_n, usb_configured, usb_suspended;
    logic wakeup_enable, suspend_pulldown_en, rx_in_valid, tx_out_ready;
    logic [7:0] flush_ms, rx_in_data, tx_out_data, fifo_data_out, d_in;
    logic rd_n, wr, data_oe, rx_n, rx_oe, rx_pin, tx_n, tx_oe, pwr_n;
    logic pull_lo, resume, rx_in_ready, tx_out_valid, tx_flush;
    logic [7:0] exp_rx[$];
    logic [7:0] exp_tx[$];
    logic oe_q = 1'b0;
    integer seed;
    int n_fail = 0;
    int n_compared = 0;
    int i, cyc;
    usb_parallel_fifo_port #(.WAKE_CYCLES(WK), .MS_CYCLES(MS),
        .RX_DEPTH(DP), .TX_DEPTH(DP)) dut (.core_clk(core_clk), .rst(rst),
        .ext_reset_n(ext_reset_n), .rd_strobe_n(rd_n), .wr_strobe(wr),
        .fifo_data_in(d_in), .fifo_data_out(fifo_data_out),
        .fifo_data_oe(data_oe), .rx_byte_avail_n(rx_n),
        .rx_byte_avail_oe(rx_oe), .rx_byte_avail_in(rx_pin),
        .tx_space_avail_n(tx_n), .tx_space_avail_oe(tx_oe),
        .usb_power_ok_n(pwr_n), .pins_pull_low(pull_lo),
        .usb_configured(usb_configured), .usb_suspended(usb_suspended),
        .wakeup_enable(wakeup_enable),
        .suspend_pulldown_en(suspend_pulldown_en), .flush_ms(flush_ms),
        .resume_request(resume), .rx_in_data(rx_in_data),
        .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
        .tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid),
        .tx_out_ready(tx_out_ready), .tx_flush(tx_flush));
    fifo_host_model host (.core_clk(core_clk), .fifo_data_oe(data_oe),
        .fifo_data_out(fifo_data_out), .rx_byte_avail_oe(rx_oe),
        .rx_byte_avail_n(rx_n), .rd_strobe_n(rd_n), .wr_strobe(wr),
        .fifo_data_in(d_in), .rx_pin(rx_pin));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return pwr_n;
            1: return tx_flush;
            2: return resume;
            3: return rx_n;
            5: return tx_oe;
            default: return tx_n;
        endcase
    endfunction
    // Bounded wait for a status output, cycles spent in cyc
    task automatic wait_bit(input int k, input logic v, input int lim);
        for (cyc = 0; cyc < lim && pick(k) !== v; cyc++) begin
            @(posedge core_clk);
            #2;
        end
        if (pick(k) !== v) begin
            n_fail++;
            $display("BAD wait %0d expected %b seen %b", k, v, pick(k));
            test_done();
        end
    endtask
    // Watcher: each result takes the oldest expectation
    always @(posedge core_clk) begin
        oe_q <= data_oe;
        if (data_oe === 1'b1 && oe_q === 1'b0) begin
            if (exp_rx.size() == 0) check("rx none", 8'h01, 8'h00);
            else check("rx data", fifo_data_out, exp_rx.pop_front());
        end
        if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) begin
            if (exp_tx.size() == 0) check("tx none", 8'h01, 8'h00);
            else check("tx data", tx_out_data, exp_tx.pop_front());
        end
    end
    initial begin
        seed = 32'h64e19147;
        rst = 1'b1;
        ext_reset_n = 1'b1;
        {usb_configured, usb_suspended, wakeup_enable} = 3'h0;
        suspend_pulldown_en = 1'b0;
        flush_ms = 8'h02;
        rx_in_data = 8'h00;
        {rx_in_valid, tx_out_ready} = 2'h0;
        repeat (20) @(posedge core_clk);
        check("status oe", {6'h00, rx_oe, tx_oe}, 8'h00);
        check("power rst", {7'h00, pwr_n}, 8'h01);
        #2 rst = 1'b0;
        wait_bit(4, 1'b0, 10);
        wait_bit(5, 1'b1, 10);
        check("tx oe", {7'h00, tx_oe}, 8'h01);
        usb_configured = 1'b1;
        wait_bit(0, 1'b0, 10);
        $display("test reset and power done");
        // Fill receive queue to refusal, back-to-back pushes
        rx_in_valid = 1'b1;
        for (i = 0; i < DP; i++) begin
            rx_in_data = $random(seed);
            exp_rx.push_back(rx_in_data);
            @(posedge core_clk) #2;
        end
        rx_in_valid = 1'b0;
        check("rx full", {7'h00, rx_in_ready}, 8'h00);
        for (i = 0; i < DP; i++) begin
            wait_bit(3, 1'b0, 10);
            host.read_byte();
        end
        wait_bit(3, 1'b1, 10);
        repeat (6) @(posedge core_clk);
        #2;
        check("rx idle oe", {7'h00, data_oe}, 8'h00);
        check("rx drained", exp_rx.size(), 8'h00);
        $display("test receive done");
        // Fill transmit queue until refused, then let it time out
        for (i = 0; i < DP + 2 && tx_n === 1'b0; i++) begin
            exp_tx.push_back($random(seed));
            host.write_byte(exp_tx[$]);
        end
        check("tx count", i, DP);
        check("tx full", {7'h00, tx_n}, 8'h01);
        wait_bit(1, 1'b1, 4 * MS);
        check("flush time", cyc >= 2*MS-6 && cyc <= 2*MS+4, 1);
        @(posedge core_clk) #2;
        tx_out_ready = 1'b1;
        wait_bit(4, 1'b0, 20);
        repeat (DP) @(posedge core_clk);
        #2;
        check("tx drained", exp_tx.size(), 8'h00);
        $display("test transmit done");
        // Port reset pin floats the status outputs
        ext_reset_n = 1'b0;
        repeat (4) @(posedge core_clk);
        check("ext rst oe", {6'h00, rx_oe, tx_oe}, 8'h00);
        #2 ext_reset_n = 1'b1;
        wait_bit(4, 1'b0, 10);
        wait_bit(5, 1'b1, 10);
        $display("test port reset done");
        // Suspend with wakeup: pin turns input, strobe asks resume
        {usb_suspended, wakeup_enable, suspend_pulldown_en} = 3'h7;
        wait_bit(0, 1'b1, 10);
        repeat (3) @(posedge core_clk);
        check("rx pin input", {7'h00, rx_oe}, 8'h00);
        check("pull low", {7'h00, pull_lo}, 8'h01);
        fork
            host.wake_strobe(WK + 10);
            wait_bit(2, 1'b1, WK + 20);
        join
        check("wake time", cyc >= WK - 2, 1);
        $display("test wakeup done");
        test_done();
    end
endmodule
`default_nettype wire
